// File: hw/tdcp_event_packer.sv
// Event word packer: eight timing inputs to a list-mode word stream.
// Assumes asynchronous input pins, one AHB-Lite master, a host sink with ready.
//
// Chosen here: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps

// Summary of operation
// - Each word is 4 or 8 bytes, chosen from the sweep range and the sweep-omit setting.
// - The channel number sits in bits 3 to 0.
// - Bit 4 is zero for a rising edge and one for a falling edge.
// - The 16-bit time value sits in bits 20 to 5.
// - The low ten bits of the sweep count sit in bits 30 to 21.
// - Bit 31 flags that event data were lost.
// - Each input feeds the stream on its own, as soon as possible, with no cross-channel ordering.
// - The sweep count goes into every word unless software omits it.
// - Each of the eight inputs has its own sampling enable and a disabled one makes no words.
// - Each input detects the rising edge, the falling edge or both.
// - An enabled window limit stops the run once its in-window count passes the preset.
// - An event counts for the window only if lower <= time < upper.
// - The time counter advances once every 32 dwell units.
module tdcp_event_packer
	import tdcp_pkg::*;
#(
	parameter int NCH_P = 8,
	parameter int TICK_P = DWELL_PER_TICK
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic start_input,
	input wire logic [6:0] stop_channel_inputs,
	output tdcp_word_s ev_word,
	output logic ev_valid,
	input wire logic ev_ready,
	output logic meas_running
);

	// ****************************************
	// Bus slave
	// ****************************************
	logic wr_pend_q;
	logic [7:0] wr_addr_q;
	logic [31:0] ctrl_q, chcfg_q, range_q;
	logic [31:0] lim_q [NCH_P];
	logic [31:0] pre_q [NCH_P];
	logic [15:0] roi_cnt_q [NCH_P];
	logic roi_stop_q, lost_q, run_q;
	logic [15:0] sweep_q;
	logic [1:0] cnt_q;
	logic [31:0] rd_mux;
	wire addr_ok = hsel & hready & htrans[1];
	wire do_wr = wr_pend_q;
	wire [2:0] wr_idx = wr_addr_q[4:2];
	wire [2:0] rd_idx = haddr[4:2];
	wire wr_lim = do_wr & (wr_addr_q[7:5] == A_LIM_BASE[7:5]);
	wire wr_pre = do_wr & (wr_addr_q[7:5] == A_PRE_BASE[7:5]);
	wire wr_ctrl = do_wr & (wr_addr_q == A_CTRL);
	wire run_start = wr_ctrl & hwdata[CTRL_RUN] & ~run_q;

	always_comb begin
		rd_mux = 32'h0000_0000;
		if (haddr == A_CTRL) begin
			rd_mux = {ctrl_q[31:1], run_q};
		end else if (haddr == A_STAT) begin
			rd_mux = {27'h000_0000, cnt_q, lost_q, roi_stop_q, run_q};
		end else if (haddr == A_CHCFG) begin
			rd_mux = chcfg_q;
		end else if (haddr == A_RANGE) begin
			rd_mux = range_q;
		end else if (haddr == A_SWEEP) begin
			rd_mux = {16'h0000, sweep_q};
		end else if (haddr[7:5] == A_LIM_BASE[7:5]) begin
			rd_mux = lim_q[rd_idx];
		end else if (haddr[7:5] == A_PRE_BASE[7:5]) begin
			rd_mux = {roi_cnt_q[rd_idx], pre_q[rd_idx][15:0]};
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b0;
			hresp <= 1'b0;
		end else begin
			wr_pend_q <= addr_ok & hwrite;
			wr_addr_q <= haddr;
			hrdata <= (addr_ok & ~hwrite) ? rd_mux : 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_q <= 32'h0000_0000;
			chcfg_q <= CHCFG_RST;
			range_q <= RANGE_RST;
		end else begin
			if (wr_ctrl) ctrl_q <= hwdata;
			if (do_wr & (wr_addr_q == A_CHCFG)) chcfg_q <= hwdata;
			if (do_wr & (wr_addr_q == A_RANGE)) range_q <= hwdata;
		end
	end

	// ****************************************
	// Time base and sweep counter
	// ****************************************
	localparam int PW = $clog2(TICK_P);
	logic [PW-1:0] presc_q;
	logic [31:0] time_q;
	logic [NCH_P-1:0] rise, fall;
	wire tick = (presc_q == PW'(TICK_P - 1));
	wire new_sweep = run_q & (rise[0] | fall[0]);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			presc_q <= '0;
			time_q <= 32'h0000_0000;
			sweep_q <= 16'h0000;
		end else if (run_start) begin
			presc_q <= '0;
			time_q <= 32'h0000_0000;
			sweep_q <= 16'h0000;
		end else if (new_sweep) begin
			presc_q <= '0;
			time_q <= 32'h0000_0000;
			sweep_q <= sweep_q + 16'h0001;
		end else if (run_q) begin
			presc_q <= tick ? '0 : presc_q + PW'(1);
			if (tick) time_q <= time_q + 32'h0000_0001;
		end
	end

	// ****************************************
	// Per-input capture and window count
	// ****************************************
	wire [NCH_P-1:0] pins = {stop_channel_inputs, start_input};
	wire [NCH_P-1:0] ch_en = chcfg_q[CHCFG_EN_LSB +: NCH_P];
	wire [NCH_P-1:0] roi_en = chcfg_q[CHCFG_ROI_LSB +: NCH_P];
	logic [NCH_P-1:0] pend_q, det, grant, load, ovf, roi_in, roi_over;
	tdcp_evt_s evt_q [NCH_P];

	genvar g;
	for (g = 0; g < NCH_P; g++) begin : g_ch
		logic s1_q, s2_q, s3_q, lvl_q;
		wire [1:0] esel = chcfg_q[CHCFG_EDGE_LSB + 2 * g +: 2];
		wire [15:0] lo = lim_q[g][15:0];
		wire [15:0] hi = lim_q[g][31:16];
		wire settled = (s2_q == s3_q);
		assign rise[g] = settled & s3_q & ~lvl_q & esel[0];
		assign fall[g] = settled & ~s3_q & lvl_q & esel[1];
		assign det[g] = run_q & ch_en[g] & (rise[g] | fall[g]);
		assign load[g] = det[g] & (~pend_q[g] | grant[g]);
		assign ovf[g] = det[g] & pend_q[g] & ~grant[g];
		assign roi_in[g] = det[g] & (time_q >= {16'h0000, lo}) & (time_q < {16'h0000, hi});
		assign roi_over[g] = roi_en[g] & roi_in[g] & (roi_cnt_q[g] >= pre_q[g][15:0]);

		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				s1_q <= 1'b0;
				s2_q <= 1'b0;
				s3_q <= 1'b0;
				lvl_q <= 1'b0;
				pend_q[g] <= 1'b0;
				evt_q[g] <= '0;
				lim_q[g] <= LIM_RST;
				pre_q[g] <= PRE_RST;
				roi_cnt_q[g] <= 16'h0000;
			end else begin
				s1_q <= pins[g];
				s2_q <= s1_q;
				s3_q <= s2_q;
				if (settled) lvl_q <= s3_q;
				pend_q[g] <= load[g] | (pend_q[g] & ~grant[g] & run_q);
				if (load[g]) evt_q[g] <= '{fall: fall[g], tim: time_q, swp: sweep_q};
				if (wr_lim & (wr_idx == 3'(g))) lim_q[g] <= hwdata;
				if (wr_pre & (wr_idx == 3'(g))) pre_q[g] <= hwdata;
				if (run_start) begin
					roi_cnt_q[g] <= 16'h0000;
				end else if (roi_in[g] & (roi_cnt_q[g] != 16'hFFFF)) begin
					roi_cnt_q[g] <= roi_cnt_q[g] + 16'h0001;
				end
			end
		end
	end

	// ****************************************
	// Run control
	// ****************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			run_q <= 1'b0;
			roi_stop_q <= 1'b0;
			meas_running <= 1'b0;
		end else begin
			if (|roi_over) begin
				run_q <= 1'b0;
				roi_stop_q <= 1'b1;
			end else if (wr_ctrl) begin
				run_q <= hwdata[CTRL_RUN];
				if (hwdata[CTRL_RUN]) roi_stop_q <= 1'b0;
			end
			meas_running <= run_q & ~(|roi_over);
		end
	end

	// ****************************************
	// Arbitration and word assembly
	// ****************************************
	logic push_ok, push, pop;
	tdcp_word_s w_new;
	tdcp_evt_s ge;
	logic [3:0] gch;
	wire omit = ctrl_q[CTRL_OMIT];
	wire wide = (range_q > NARROW_MAX) & ~(omit & (range_q <= OMIT_MAX));

	always_comb begin
		grant = '0;
		gch = 4'h0;
		for (int i = NCH_P - 1; i >= 0; i--) begin
			if (pend_q[i]) begin
				gch = 4'(i);
			end
		end
		if (|pend_q) grant[gch[2:0]] = push_ok;
	end

	assign ge = evt_q[gch[2:0]];
	assign push = |grant;

	always_comb begin
		w_new.wide = wide;
		w_new.data = 64'h0000_0000_0000_0000;
		w_new.data[W_CH_LSB +: 4] = gch;
		w_new.data[W_EDGE] = ge.fall;
		w_new.data[W_TIME_LSB +: 16] = ge.tim[15:0];
		if (!omit) begin
			w_new.data[W_SWP_LSB +: 10] = ge.swp[9:0];
		end else if (!wide) begin
			w_new.data[W_SWP_LSB +: 10] = ge.tim[25:16];
		end
		w_new.data[W_LOST] = lost_q | (|ovf);
		if (wide) begin
			w_new.data[63:32] = {ge.tim[31:16], omit ? 16'h0000 : ge.swp};
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lost_q <= 1'b0;
		end else begin
			lost_q <= (|ovf) | (lost_q & ~push);
		end
	end

	// ****************************************
	// Two-entry output buffer
	// ****************************************
	tdcp_word_s buf_q [2];
	assign pop = ev_valid & ev_ready;
	assign push_ok = (cnt_q != 2'h2) | pop;
	wire [1:0] cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			buf_q[0] <= '0;
			buf_q[1] <= '0;
			cnt_q <= 2'h0;
			ev_valid <= 1'b0;
		end else begin
			if (pop & (cnt_q == 2'h2)) begin
				buf_q[0] <= buf_q[1];
			end else if (push & ((cnt_q == 2'h0) | (pop & (cnt_q == 2'h1)))) begin
				buf_q[0] <= w_new;
			end
			if (push & (((cnt_q == 2'h1) & ~pop) | (cnt_q == 2'h2))) buf_q[1] <= w_new;
			cnt_q <= cnt_d;
			ev_valid <= (cnt_d != 2'h0);
		end
	end

	assign ev_word = buf_q[0];

	// ****************************************
	// Checks
	// ****************************************
	property p_chan_field;
		@(posedge hclk) disable iff (!hresetn) ev_valid |-> (ev_word.data[3:0] < 4'(NCH_P));
	endproperty
	a_chan_field: assert property (p_chan_field) else $error("channel field out of range");

	property p_narrow_top;
		@(posedge hclk) disable iff (!hresetn) (ev_valid & ~ev_word.wide) |-> (ev_word.data[63:32] == 32'h0);
	endproperty
	a_narrow_top: assert property (p_narrow_top) else $error("narrow word has upper bits");

	property p_rise_only;
		@(posedge hclk) disable iff (!hresetn)
			(push & (chcfg_q[CHCFG_EDGE_LSB + 2 * gch[2:0] +: 2] == EDGE_RISE) & ~$past(wr_pend_q)) |=>
			(buf_q[cnt_q[1]].data[W_EDGE] == 1'b0);
	endproperty
	a_rise_only: assert property (p_rise_only) else $error("falling flag on rising-only input");

	property p_time_tick;
		@(posedge hclk) disable iff (!hresetn)
			(run_q & tick & ~new_sweep & ~run_start) |=> (time_q == $past(time_q) + 32'h1);
	endproperty
	a_time_tick: assert property (p_time_tick) else $error("time counter missed its tick");

	sequence s_no_tick;
		run_q & ~tick & ~new_sweep & ~run_start;
	endsequence
	property p_time_hold;
		@(posedge hclk) disable iff (!hresetn) s_no_tick |=> $stable(time_q);
	endproperty
	a_time_hold: assert property (p_time_hold) else $error("time counter moved between ticks");

	property p_disabled;
		@(posedge hclk) disable iff (!hresetn) ~(|(load & ~ch_en));
	endproperty
	a_disabled: assert property (p_disabled) else $error("disabled input captured an event");

	property p_lost_next;
		@(posedge hclk) disable iff (!hresetn) (|ovf) ##1 (push [*1]) |-> w_new.data[W_LOST];
	endproperty
	a_lost_next: assert property (p_lost_next) else $error("lost flag missing after overflow");

	property p_roi_stop;
		@(posedge hclk) disable iff (!hresetn) (|roi_over) |=> (~run_q & roi_stop_q) ##1 ~meas_running;
	endproperty
	a_roi_stop: assert property (p_roi_stop) else $error("window limit did not stop the run");

	property p_roi_window;
		@(posedge hclk) disable iff (!hresetn)
			(~run_start & (roi_cnt_q[1] != 16'hFFFF)) ##1 (roi_cnt_q[1] != $past(roi_cnt_q[1])) |-> $past(roi_in[1]);
	endproperty
	a_roi_window: assert property (p_roi_window) else $error("count moved outside the window");

	property p_buf_hold;
		@(posedge hclk) disable iff (!hresetn) (ev_valid & ~ev_ready) |=> (ev_valid & $stable(ev_word));
	endproperty
	a_buf_hold: assert property (p_buf_hold) else $error("stalled word changed");

endmodule

// File: hw/tdcp_pkg.sv
// Constants, field layouts and carrier types for the event word packer.
// Assumes a 32-bit AHB-Lite register bus and eight discriminated inputs.
package tdcp_pkg;

	// ****************************************
	// Register map (byte addresses)
	// ****************************************
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_STAT = 8'h04;
	localparam logic [7:0] A_CHCFG = 8'h08;
	localparam logic [7:0] A_RANGE = 8'h0C;
	localparam logic [7:0] A_SWEEP = 8'h10;
	localparam logic [7:0] A_LIM_BASE = 8'h20;
	localparam logic [7:0] A_PRE_BASE = 8'h40;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int CTRL_RUN = 0;
	localparam int CTRL_OMIT = 1;
	localparam int CHCFG_EN_LSB = 0;
	localparam int CHCFG_EDGE_LSB = 8;
	localparam int CHCFG_ROI_LSB = 24;
	localparam int W_CH_LSB = 0;
	localparam int W_EDGE = 4;
	localparam int W_TIME_LSB = 5;
	localparam int W_SWP_LSB = 21;
	localparam int W_LOST = 31;

	// ****************************************
	// Reset values and limits
	// ****************************************
	localparam logic [31:0] CHCFG_RST = 32'h00AA_AA00;
	localparam logic [31:0] RANGE_RST = 32'h0000_1000;
	localparam logic [31:0] LIM_RST = 32'h0800_0000;
	localparam logic [31:0] PRE_RST = 32'h0000_0000;
	localparam logic [31:0] NARROW_MAX = 32'h0000_FFFF;
	localparam logic [31:0] OMIT_MAX = 32'h03FF_FFFF;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;

	// ****************************************
	// Timing
	// ****************************************
	localparam int DWELL_PER_TICK = 32;

	// ****************************************
	// Carriers
	// ****************************************
	typedef struct packed {
		logic wide;
		logic [63:0] data;
	} tdcp_word_s;

	typedef struct packed {
		logic fall;
		logic [31:0] tim;
		logic [15:0] swp;
	} tdcp_evt_s;

endpackage

// File: test/tdc_event_word_packer_test.sv
// Testbench for the event word packer: bus tasks, pin stimulus, queue model.
// Assumes the package, the packer and the host sink model are compiled first.
`timescale 1ns/1ps
module tdc_event_word_packer_test;
	import tdcp_pkg::*;
	logic hclk, hresetn, hsel, hwrite, hold, got, wide;
	logic hreadyout, hresp, ev_valid, ev_ready, meas_running;
	logic [7:0] haddr, pins;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] hwdata, hrdata, rd, cfg, s;
	tdcp_word_s ev_word, got_word;
	logic [63:0] q[8][$];
	int error_cnt, checks, sw;

	tdcp_event_packer #(.TICK_P(4)) tdcp_event_packer_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .start_input(pins[0]),
		.stop_channel_inputs(pins[7:1]), .ev_word(ev_word), .ev_valid(ev_valid), .ev_ready(ev_ready),
		.meas_running(meas_running));
	tdcp_host_sink tdcp_host_sink_inst (.hclk(hclk), .hresetn(hresetn), .hold(hold), .ev_word(ev_word),
		.ev_valid(ev_valid), .ev_ready(ev_ready), .got(got), .got_word(got_word));

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [31:0] xs();
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		return s;
	endfunction

	task automatic chk(input logic [63:0] a, input logic [63:0] e);
		checks++;
		if (a !== e) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, a, e);
		end
	endtask

	task automatic summarize();
		if (error_cnt == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= wd;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd = hrdata;
	endtask

	// Toggle one pin and queue the word the model expects
	task automatic tog(input int n);
		logic nl;
		nl = !pins[n];
		pins[n] <= nl;
		if (cfg[n] && cfg[8 + 2 * n + (nl ? 0 : 1)]) begin
			if (n == 0)
				sw++;
			q[n].push_back({wide ? {16'h0000, 16'(sw)} : 32'h0, 1'b0, 10'(sw), 16'h0000, !nl, 4'(n)});
		end
		repeat (12) @(posedge hclk);
	endtask

	// ****************************************
	// Stream monitor against the model
	// ****************************************
	always @(posedge hclk) begin
		logic [63:0] m;
		int c;
		if (got === 1'b1) begin
			c = int'(got_word.data[2:0]);
			m = got_word.wide ? 64'h0000_FFFF_FFE0_001F : 64'hFFFF_FFFF_FFE0_001F;
			if (c == 0)
				m = m & 64'hFFFF_0000_801F_FFFF;
			chk(64'(got_word.wide), 64'(wide));
			chk(64'(q[c].size() > 0), 64'h1);
			if (q[c].size() > 0)
				chk(got_word.data & m, q[c].pop_front() & m);
		end
	end

	always @(posedge hclk) hold <= 1'(xs() >> 31);

	initial begin
		hclk = 1'b0;
		forever #20 hclk = ~hclk;
	end

	initial begin
		repeat (8000) @(posedge hclk);
		error_cnt++;
		summarize();
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		s = 32'hA272;
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 8'h00;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		pins = 8'h00;
		cfg = CHCFG_RST;
		wide = 1'b0;
		sw = 0;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(1'b0, A_CHCFG, 32'h0);
		chk(rd, CHCFG_RST);
		bus(1'b0, A_RANGE, 32'h0);
		chk(rd, RANGE_RST);
		bus(1'b0, 8'hFC, 32'h0);
		chk(rd, 64'h0);
		cfg = 32'h00FF_E5FF;
		bus(1'b1, A_CHCFG, cfg);
		bus(1'b1, A_CTRL, 32'h1);
		for (int i = 0; i < 3; i++)
			tog(0);
		repeat (40) tog(int'(1 + xs() % 7));
		cfg[3] = 1'b0;
		bus(1'b1, A_CHCFG, cfg);
		repeat (4) tog(3);
		wide = 1'b1;
		bus(1'b1, A_RANGE, 32'h0001_0000);
		repeat (2) tog(2);
		repeat (20) @(posedge hclk);
		wide = 1'b0;
		bus(1'b1, A_RANGE, RANGE_RST);
		bus(1'b1, A_PRE_BASE + 8'h04, 32'h1);
		cfg[25] = 1'b1;
		bus(1'b1, A_CHCFG, cfg);
		bus(1'b1, A_CTRL, 32'h0);
		bus(1'b1, A_CTRL, 32'h1);
		sw = 0;
		bus(1'b1, A_LIM_BASE + 8'h04, 32'h0800_0100);
		repeat (2) tog(1);
		bus(1'b0, A_PRE_BASE + 8'h04, 32'h0);
		chk(rd, 64'h1);
		chk(64'(meas_running), 64'h1);
		bus(1'b1, A_LIM_BASE + 8'h04, LIM_RST);
		if (pins[1])
			tog(1);
		tog(1);
		chk(64'(meas_running), 64'h1);
		tog(1);
		tog(1);
		chk(64'(meas_running), 64'h0);
		bus(1'b0, A_STAT, 32'h0);
		chk(64'(rd[1]), 64'h1);
		repeat (30) @(posedge hclk);
		for (int i = 0; i < 8; i++)
			chk(64'(q[i].size()), 64'h0);
		summarize();
	end
endmodule

// File: test/tdcp_host_sink.sv
// Host sink model: takes words from the event stream, with stalls on request.
// Assumes the bench drives hold from its own random source.
`timescale 1ns/1ps
module tdcp_host_sink
	import tdcp_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hold,
	input wire tdcp_word_s ev_word,
	input wire logic ev_valid,
	output logic ev_ready,
	output logic got,
	output tdcp_word_s got_word
);
	// ****************************************
	// Ready is the registered inverse of hold, taken word reported next cycle
	// ****************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ev_ready <= 1'b0;
			got <= 1'b0;
			got_word <= '0;
		end else begin
			ev_ready <= !hold;
			got <= ev_valid && ev_ready;
			got_word <= ev_word;
		end
	end
endmodule
